// File: verilog/ddmc_pkg.sv
// package for the dual converter mode control block
// assumes a single 25 MHz system clock domain
package ddmc_pkg;

   localparam int DDMC_CLK_MHZ = 25;
   localparam int DDMC_DATA_WIDTH = 10;
   localparam int DDMC_GAIN_WIDTH = 4;

   // control word field positions on the port A inputs
   localparam int DDMC_POS_POWERDOWN = 9;
   localparam int DDMC_POS_ENABLE = 8;
   localparam int DDMC_POS_FILTER2 = 7;
   localparam int DDMC_POS_FILTER1 = 6;
   localparam int DDMC_POS_GAIN_HI = 5;
   localparam int DDMC_POS_GAIN_LO = 2;

   // reset values of the configuration word
   localparam logic DDMC_RST_POWERDOWN = 1'h0;
   localparam logic DDMC_RST_ENABLE = 1'h1;
   localparam logic DDMC_RST_FILTER2 = 1'h0;
   localparam logic DDMC_RST_FILTER1 = 1'h0;
   localparam logic [3:0] DDMC_RST_GAIN = 4'h8;

   // wake time from standby, nanoseconds
   localparam int DDMC_WAKE_NS = 700;
   localparam int DDMC_WAKE_CYCLES = (DDMC_WAKE_NS * DDMC_CLK_MHZ + 999) / 1000;

   // filter tap counts of the two cascaded stages
   localparam int DDMC_TAPS_STAGE1 = 43;
   localparam int DDMC_TAPS_STAGE2 = 23;

   typedef struct packed {
      logic powerdown_bit;
      logic converter_enable_bit;
      logic second_filter_enable;
      logic first_filter_enable;
      logic [3:0] gain_trim;
   } ddmc_config_type;

   typedef struct packed {
      logic [9:0] chan_a;
      logic [9:0] chan_b;
   } ddmc_pair_type;

   typedef enum logic [2:0] {
      DDMC_ST_NORMAL = 3'h1,
      DDMC_ST_STANDBY = 3'h2,
      DDMC_ST_WAKING = 3'h4
   } ddmc_state_type;

   typedef enum logic [1:0] {
      DDMC_RATE_1X = 2'h0,
      DDMC_RATE_2X = 2'h1,
      DDMC_RATE_4X = 2'h2,
      DDMC_RATE_BAD = 2'h3
   } ddmc_rate_type;

endpackage

// File: verilog/ddmc_skid.sv
// two-entry buffer for sample pairs between capture and output stage
// assumes source and sink on SYS_CLK
`timescale 1ns/1ps
module ddmc_skid
(
   // clock and reset
   input wire logic clk,
   input wire logic arst_n,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire ddmc_pkg::ddmc_pair_type in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output ddmc_pkg::ddmc_pair_type out_data
);
   import ddmc_pkg::*;
   ddmc_pair_type mem [0:1];
   logic wr_ptr;
   logic rd_ptr;
   logic [1:0] count;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = mem[rd_ptr];

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= 1'h0;
         rd_ptr <= 1'h0;
         count <= 2'h0;
      end else begin
         wr_ptr <= wr_ptr ^ push;
         rd_ptr <= rd_ptr ^ pop;
         count <= count + {1'h0, push} - {1'h0, pop};
      end
   end

   never_over_a: assert property (@(posedge clk) disable iff (!arst_n) count <= 2'h2)
      else $error("buffer count above depth");
endmodule // ddmc_skid

// File: verilog/ddmc_top.sv
// converter mode control: config word capture, power states, interpolation select, sample path
// assumes data clock, strobe and pins asynchronous to SYS_CLK; link clock much slower than SYS_CLK
`timescale 1ns/1ps
module ddmc_top
(
   // clock and reset
   input wire logic SYS_CLK,
   input wire logic ARST_N,
   // data port pins and link clock
   input wire logic [9:0] PORT_A_INPUTS,
   input wire logic [9:0] PORT_B_INPUTS,
   input wire logic DATA_CLK,
   input wire logic INTERLEAVE_SELECT,
   input wire logic CONFIG_WRITE_STROBE_N,
   // converter side
   input wire logic CORE_READY,
   output ddmc_pkg::ddmc_pair_type CORE_SAMPLES,
   output logic CORE_VALID,
   output ddmc_pkg::ddmc_config_type CONFIG,
   output ddmc_pkg::ddmc_rate_type RATE,
   output logic STAGE1_ON,
   output logic STAGE2_ON,
   output logic POWERED_DOWN,
   output logic STANDBY,
   output logic CONVERTING,
   output logic SAMPLE_DROPPED
);
   import ddmc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // synchronisers: every data port pin passes two flops before use
   localparam int NSYNC = 22;
   // reset to idle pin levels (strobe high, link clock low) so no false edge follows reset
   localparam logic [NSYNC-1:0] SYNC_IDLE = 22'h000001;
   wire [NSYNC-1:0] raw = {PORT_A_INPUTS, PORT_B_INPUTS, DATA_CLK, CONFIG_WRITE_STROBE_N};
   logic [NSYNC-1:0] sync1;
   logic [NSYNC-1:0] sync2;
   logic il_s1;
   logic il_s2;

   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_sync
         always_ff @(posedge SYS_CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               sync1[gi] <= SYNC_IDLE[gi];
               sync2[gi] <= SYNC_IDLE[gi];
            end else begin
               sync1[gi] <= raw[gi];
               sync2[gi] <= sync1[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         il_s1 <= 1'h0;
         il_s2 <= 1'h0;
      end else begin
         il_s1 <= INTERLEAVE_SELECT;
         il_s2 <= il_s1;
      end
   end

   wire [9:0] pa = sync2[21:12];
   wire [9:0] pb = sync2[11:2];
   wire dclk = sync2[1];
   wire strobe_n = sync2[0];

   ////////////////////////////////////////////////////////////////////////////////
   // edge detection on synchronised link clock and strobe
   logic dclk_d;
   logic strobe_d;
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         dclk_d <= 1'h0;
         strobe_d <= 1'h1;
      end else begin
         dclk_d <= dclk;
         strobe_d <= strobe_n;
      end
   end
   wire dclk_rise = dclk && !dclk_d;
   wire dclk_fall = !dclk && dclk_d;
   wire write_fall = !strobe_n && strobe_d;

   ////////////////////////////////////////////////////////////////////////////////
   // configuration word; pins are sampled by SYS_CLK so the strobe is not a clock
   ddmc_config_type cfg;
   ddmc_config_type next_cfg;
   assign next_cfg.powerdown_bit = pa[DDMC_POS_POWERDOWN];
   assign next_cfg.converter_enable_bit = pa[DDMC_POS_ENABLE];
   assign next_cfg.second_filter_enable = pa[DDMC_POS_FILTER2];
   assign next_cfg.first_filter_enable = pa[DDMC_POS_FILTER1];
   assign next_cfg.gain_trim = pa[DDMC_POS_GAIN_HI:DDMC_POS_GAIN_LO];

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cfg <= '{DDMC_RST_POWERDOWN, DDMC_RST_ENABLE, DDMC_RST_FILTER2, DDMC_RST_FILTER1,
                  DDMC_RST_GAIN};
      end else if (write_fall) begin
         cfg <= next_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // interpolation select; illegal code keeps filters off rather than guess
   wire [1:0] fsel = {cfg.second_filter_enable, cfg.first_filter_enable};
   wire ddmc_rate_type next_rate = ddmc_rate_type'((fsel == 2'h3) ? DDMC_RATE_4X :
                                   (fsel == 2'h1) ? DDMC_RATE_2X :
                                   (fsel == 2'h0) ? DDMC_RATE_1X : DDMC_RATE_BAD);
   wire run_ok = !cfg.powerdown_bit && cfg.converter_enable_bit;
   wire next_stage1 = run_ok && (next_rate == DDMC_RATE_2X || next_rate == DDMC_RATE_4X);
   wire next_stage2 = run_ok && (next_rate == DDMC_RATE_4X);

   ////////////////////////////////////////////////////////////////////////////////
   // power state machine
   ddmc_state_type state;
   ddmc_state_type next_state;
   logic [4:0] wake_cnt;
   localparam logic [4:0] WAKE_LAST = 5'(DDMC_WAKE_CYCLES - 1);

   always_comb begin
      next_state = state;
      case (state)
         DDMC_ST_NORMAL: begin
            if (!run_ok) begin
               next_state = DDMC_ST_STANDBY;
            end
         end
         DDMC_ST_STANDBY: begin
            if (run_ok) begin
               next_state = DDMC_ST_WAKING;
            end
         end
         DDMC_ST_WAKING: begin
            if (!run_ok) begin
               next_state = DDMC_ST_STANDBY;
            end else if (wake_cnt == WAKE_LAST) begin
               next_state = DDMC_ST_NORMAL;
            end
         end
         default: begin
            next_state = DDMC_ST_STANDBY;
         end
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= DDMC_ST_NORMAL;
         wake_cnt <= 5'h00;
      end else begin
         state <= next_state;
         wake_cnt <= (state == DDMC_ST_WAKING) ? wake_cnt + 5'h01 : 5'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sample capture: B waits in a hold register, pair leaves on the rising edge
   logic [9:0] hold_b;
   logic [9:0] lat_a;
   logic [9:0] lat_b;
   logic lat_valid;
   wire in_ready;
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         hold_b <= 10'h000;
         lat_a <= 10'h000;
         lat_b <= 10'h000;
         lat_valid <= 1'h0;
      end else begin
         if (dclk_fall) begin
            hold_b <= il_s2 ? pa : pb;
         end
         lat_valid <= dclk_rise && (state == DDMC_ST_NORMAL);
         if (dclk_rise) begin
            lat_a <= pa;
            lat_b <= hold_b;
         end
      end
   end

   wire ddmc_pair_type buf_out;
   wire buf_valid;
   ddmc_skid u_skid (
      .clk(SYS_CLK),
      .arst_n(ARST_N),
      .in_valid(lat_valid),
      .in_ready(in_ready),
      .in_data('{lat_a, lat_b}),
      .out_valid(buf_valid),
      .out_ready(CORE_READY),
      .out_data(buf_out)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // registered outputs; gain is carried to the core and applies to channel A only
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         CORE_SAMPLES <= '0;
         CORE_VALID <= 1'h0;
         CONFIG <= '{DDMC_RST_POWERDOWN, DDMC_RST_ENABLE, DDMC_RST_FILTER2, DDMC_RST_FILTER1,
                     DDMC_RST_GAIN};
         RATE <= DDMC_RATE_1X;
         STAGE1_ON <= 1'h0;
         STAGE2_ON <= 1'h0;
         POWERED_DOWN <= 1'h0;
         STANDBY <= 1'h0;
         CONVERTING <= 1'h1;
         SAMPLE_DROPPED <= 1'h0;
      end else begin
         CORE_SAMPLES <= buf_out;
         CORE_VALID <= buf_valid && CORE_READY;
         CONFIG <= cfg;
         RATE <= next_rate;
         STAGE1_ON <= next_stage1;
         STAGE2_ON <= next_stage2;
         POWERED_DOWN <= cfg.powerdown_bit;
         STANDBY <= !cfg.powerdown_bit && !cfg.converter_enable_bit;
         CONVERTING <= (next_state == DDMC_ST_NORMAL);
         SAMPLE_DROPPED <= lat_valid && !in_ready;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   pd_forces_off_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
      cfg.powerdown_bit |=> POWERED_DOWN && !CONVERTING && !STAGE1_ON)
      else $error("power-down bit did not stop the converter");
   standby_state_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
      (!cfg.powerdown_bit && !cfg.converter_enable_bit) |=> STANDBY && !CONVERTING)
      else $error("standby not entered");
   four_x_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
      (run_ok && fsel == 2'h3) |=> RATE == DDMC_RATE_4X && STAGE1_ON && STAGE2_ON)
      else $error("4x select wrong");
   two_x_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
      (run_ok && fsel == 2'h1) |=> RATE == DDMC_RATE_2X && STAGE1_ON && !STAGE2_ON)
      else $error("2x select wrong");
   bypass_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
      (fsel == 2'h0) |=> RATE == DDMC_RATE_1X && !STAGE1_ON && !STAGE2_ON)
      else $error("bypass left filters on");
   capture_word_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
      write_fall |=> cfg.gain_trim == $past(pa[5:2]) && cfg.powerdown_bit == $past(pa[9]))
      else $error("config word not captured on strobe fall");
   hold_cfg_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
      !write_fall |=> $stable(cfg))
      else $error("config changed without strobe fall");
   wake_time_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
      (state == DDMC_ST_STANDBY && run_ok) |=> !CONVERTING [*8])
      else $error("converter woke too early");
   // helper: cycles of requested running since standby was left; saturates
   logic [4:0] run_len;
   always_ff @(posedge SYS_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         run_len <= 5'h00;
      end else begin
         run_len <= (!run_ok || state == DDMC_ST_STANDBY) ? 5'h00 : run_len + {4'h0, run_len != 5'h1F};
      end
   end
   wake_done_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
      run_len >= 5'(DDMC_WAKE_CYCLES) |-> CONVERTING)
      else $error("converter did not wake in time");
   latency_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
      (dclk_rise && state == DDMC_ST_NORMAL) |=> lat_valid && lat_a == $past(pa))
      else $error("sample not captured on data clock rise");

   c_write: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) write_fall);
   c_wake: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) state == DDMC_ST_WAKING ##1 CONVERTING);
   c_4x: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) RATE == DDMC_RATE_4X);
   c_stall: cover property (@(posedge SYS_CLK) disable iff (!ARST_N) SAMPLE_DROPPED);
endmodule // ddmc_top

// File: verification/ddmc_host_model.sv
// host model: drives port pins, link clock and control word strobe
// assumes 8 SYS_CLK cycles per link period, bench queue reads exp_q
`timescale 1ns/1ps
module ddmc_host_model
(
   // clock
   input wire logic clk,
   // control from bench
   input wire logic run,
   input wire logic interleave,
   // pins
   output logic [9:0] port_a,
   output logic [9:0] port_b,
   output logic data_clk,
   output logic strobe_n
);
   import ddmc_pkg::*;
   int seed = 32'hD6B0;
   logic [2:0] phase = 3'h0;
   logic [9:0] a_val = 10'h0;
   logic [9:0] b_val = 10'h0;
   logic b_on_a = 1'b0;
   logic cfg_busy = 1'b0;
   logic [9:0] cfg_val = 10'h0;
   ddmc_pair_type exp_q[$];
   initial begin
      data_clk = 1'b0;
      strobe_n = 1'b1;
   end
   // control word overrides samples only while it is written
   assign port_a = cfg_busy ? cfg_val : (interleave && b_on_a) ? b_val : a_val;
   // unused port B changes every cycle so a stale sample can never match
   assign port_b = interleave ? ~b_val ^ {7'h0, phase} : b_val;
   ////////////////////////////////////////////////////////////
   // 320 ns period, far below the rate limit; stands low between frames
   always @(posedge clk) begin
      #1;
      if (run || phase != 3'h0) begin
         case (phase)
            3'h0: begin
               data_clk = 1'b1;
               exp_q.push_back({a_val, b_val});
            end
            3'h3: begin
               b_val = 10'($random(seed));
               b_on_a = 1'b1;
            end
            3'h4: data_clk = 1'b0;
            3'h7: begin
               a_val = 10'($random(seed));
               b_on_a = 1'b0;
            end
            default: ;
         endcase
         phase = phase + 3'h1;
      end
   end
   // word held three cycles each side of the fall, slow sync needs it
   task automatic write_word(input logic [9:0] w);
      @(posedge clk);
      #1;
      cfg_val = w;
      cfg_busy = 1'b1;
      repeat (3) @(posedge clk);
      #1;
      strobe_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      cfg_busy = 1'b0;
      @(posedge clk);
      #1;
      strobe_n = 1'b1;
   endtask
endmodule // ddmc_host_model

// File: verification/dual_dac_mode_control_tb.sv
// bench: random control words and sample streams against the mode control block
// assumes ddmc_host_model as far side, checks in check()
`timescale 1ns/1ps
module dual_dac_mode_control_tb;
   import ddmc_pkg::*;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic run = 1'b0;
   logic inter = 1'b0;
   logic core_ready = 1'b1;
   logic rand_ready = 1'b0;
   logic loose = 1'b1;
   logic stay_loose = 1'b0;
   logic cur_run = 1'b1;
   logic [9:0] port_a;
   logic [9:0] port_b;
   logic data_clk;
   logic strobe_n;
   ddmc_pair_type core_samples;
   ddmc_config_type cfg_out;
   ddmc_rate_type rate;
   logic core_valid, stage1_on, stage2_on, powered_down, standby, converting, sample_dropped;
   logic [14:0] status;
   int mismatches = 0;
   int comparisons = 0;
   int drops = 0;
   int seen = 0;
   int seed = 32'hD6B0;
   logic [7:0] corners [9] = '{8'h50, 8'h70, 8'h40, 8'h3C, 8'h00, 8'hF0, 8'h4F, 8'hC8, 8'h48};

   always #20 sys_clk = ~sys_clk;
   assign status = {cfg_out, rate, stage1_on, stage2_on, powered_down, standby, converting};

   ddmc_top u_ddmc_top (.SYS_CLK(sys_clk), .ARST_N(arst_n), .PORT_A_INPUTS(port_a), .PORT_B_INPUTS(port_b),
      .DATA_CLK(data_clk), .INTERLEAVE_SELECT(inter), .CONFIG_WRITE_STROBE_N(strobe_n),
      .CORE_READY(core_ready), .CORE_SAMPLES(core_samples), .CORE_VALID(core_valid), .CONFIG(cfg_out),
      .RATE(rate), .STAGE1_ON(stage1_on), .STAGE2_ON(stage2_on), .POWERED_DOWN(powered_down),
      .STANDBY(standby), .CONVERTING(converting), .SAMPLE_DROPPED(sample_dropped));
   ddmc_host_model u_ddmc_host_model (.clk(sys_clk), .run(run), .interleave(inter), .port_a(port_a),
      .port_b(port_b), .data_clk(data_clk), .strobe_n(strobe_n));
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [19:0] got, input logic [19:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   function automatic logic [14:0] expect_status(input logic [7:0] w);
      logic on;
      logic [1:0] r;
      on = !w[7] && w[6];
      r = w[4] ? (w[5] ? 2'h2 : 2'h1) : 2'h0;
      return {w, r, on && w[4], on && w[4] && w[5], w[7], !w[7] && !w[6], on};
   endfunction
   // the host never sends the second filter alone
   function automatic logic [7:0] legal(input logic [7:0] w);
      return {w[7:6], w[5] & w[4], w[4:0]};
   endfunction
   task automatic do_write(input logic [7:0] w);
      logic prev;
      prev = cur_run;
      cur_run = !w[7] && w[6];
      u_ddmc_host_model.write_word({w, 2'($random(seed))});
      tick(8);
      check(20'(converting), 20'(prev && cur_run), "wake hold-off");
      tick(26);
      check(20'(status), 20'(expect_status(w)), "status");
   endtask
   // mode 0 steady, 1 long stall, 2 random ready
   task automatic stream(input logic il, input int mode);
      int n;
      inter = il;
      tick(4);
      u_ddmc_host_model.exp_q.delete();
      loose = 1'b1;
      stay_loose = (mode != 0);
      drops = 0;
      n = seen;
      run = 1'b1;
      core_ready = (mode != 1);
      rand_ready = (mode == 2);
      tick(48);
      rand_ready = 1'b0;
      tick(1);
      core_ready = 1'b1;
      tick(48);
      run = 1'b0;
      tick(16);
      check(20'(seen - n > 4), 20'h1, "pairs handed");
      if (mode == 1) check(20'(drops > 0), 20'h1, "drop flag");
   endtask
   ////////////////////////////////////////////////////////////
   always @(posedge sys_clk) begin
      #1;
      if (rand_ready) core_ready = 1'($random(seed));
   end
   // stalls may lose pairs, so loose mode skips to the next match
   // sampled mid-cycle, where the registered outputs have settled
   always @(negedge sys_clk) begin
      if (arst_n && core_valid === 1'b1) begin
         while (loose && u_ddmc_host_model.exp_q.size() > 0 && u_ddmc_host_model.exp_q[0] !== core_samples)
            void'(u_ddmc_host_model.exp_q.pop_front());
         if (u_ddmc_host_model.exp_q.size() == 0) begin
            check(20'h0, 20'h1, "unexpected pair");
         end else begin
            check(core_samples, u_ddmc_host_model.exp_q.pop_front(), "pair");
            if (!loose) check(20'(u_ddmc_host_model.exp_q.size()), 20'h0, "latency");
            loose = stay_loose;
         end
         seen++;
      end
      if (sample_dropped === 1'b1) drops++;
   end
   initial begin
      #400000;
      mismatches++;
      $display("[FAIL] %0t watchdog expired", $time);
      finish_test();
   end
   initial begin
      tick(8);
      arst_n = 1'b1;
      tick(2);
      check(20'(status), 20'(expect_status({DDMC_RST_POWERDOWN, DDMC_RST_ENABLE, DDMC_RST_FILTER2,
         DDMC_RST_FILTER1, DDMC_RST_GAIN})), "reset state");
      check(20'(core_valid), 20'h0, "reset valid");
      foreach (corners[i]) do_write(corners[i]);
      repeat (20) do_write(legal(8'($random(seed))));
      // random words may leave it idle; the streams need it converting
      do_write(8'h58);
      stream(1'b0, 0);
      stream(1'b1, 0);
      stream(1'b0, 1);
      stream(1'b1, 2);
      do_write(8'h08);
      // control write lands while the link clock keeps running
      loose = 1'b1;
      stay_loose = 1'b1;
      run = 1'b1;
      tick(4);
      u_ddmc_host_model.write_word(10'h123);
      cur_run = 1'b1;
      tick(40);
      check(20'(converting), 20'h1, "write while running");
      tick(40);
      run = 1'b0;
      tick(16);
      finish_test();
   end
endmodule // dual_dac_mode_control_tb
